// ---- src/asc_map.vh ----
// Purpose: register offsets, field positions, reset values, timing counts
// Assumes: included by the serial channel design files
// Notes: definitions only
`ifndef ASC_MAP_VH
`define ASC_MAP_VH
`define ASC_OFF_HOLD 3'h0
`define ASC_OFF_MASK 3'h1
`define ASC_OFF_SRC 3'h2
`define ASC_OFF_FMT 3'h3
`define ASC_OFF_MCTL 3'h4
`define ASC_OFF_LSTAT 3'h5
`define ASC_OFF_MSTAT 3'h6
`define ASC_OFF_SCR 3'h7
`define ASC_FMT_PAR_EN 3
`define ASC_FMT_EVEN 4
`define ASC_FMT_STICK 5
`define ASC_FMT_BRK 6
`define ASC_FMT_DIV 7
`define ASC_MC_LOOP 4
`define ASC_MC_IRQ_EN 3
`define ASC_RST_MASK 8'h00
`define ASC_RST_FMT 8'h00
`define ASC_RST_MCTL 8'h00
`define ASC_RST_DIV 16'h0000
`define ASC_SRC_NONE 3'h1
`define ASC_SRC_LINE 3'h6
`define ASC_SRC_RXD 3'h4
`define ASC_SRC_THE 3'h2
`define ASC_SRC_MDM 3'h0
`define ASC_START_MID 4'h7
`define ASC_BIT_TICKS 4'hf
`define ASC_FIFO_DEPTH 32
`define ASC_FIFO_AW 5
`endif

// ---- src/asc_fifo.v ----
// Purpose: transmit byte buffer between the holding register and the shifter
// Assumes: one clock, asynchronous clear
// Notes: flip-flop storage, honest full and empty
`timescale 1ns/1ps
module asc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk_i,              // Clock
  input wire sys_rst_i,          // Async reset, high
  input wire in_valid_i,         // Write request
  output wire in_ready_o,        // Space available
  input wire [WIDTH-1:0] in_data_i, // Write data
  output wire out_valid_o,       // Data available
  input wire out_ready_i,        // Read accept
  output wire [WIDTH-1:0] out_data_o // Head data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ---- src/asc_baud.v ----
// Purpose: 16x baud tick divider
// Assumes: divisor below 2 is treated as stopped
// Notes: one-cycle tick every divisor clocks
`timescale 1ns/1ps
module asc_baud (
  input wire clk_i,          // Clock
  input wire sys_rst_i,      // Async reset, high
  input wire [15:0] div_i,   // Divisor
  output reg tick_o          // 16x enable pulse
);
  reg [15:0] cnt;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= 16'h0000;
      tick_o <= 1'b0;
    end else if (div_i < 16'h0002) begin
      cnt <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt >= div_i - 16'h0001) begin
      cnt <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule

// ---- src/asc_channel.v ----
// Purpose: one asynchronous serial channel with modem control
// Assumes: bus strobes synchronous to clk_i; one strobe per access
// Notes: transmit path buffered by a 32-entry FIFO before the shifter
`timescale 1ns/1ps
`include "asc_map.vh"
//
// Contract
// - Holding-empty flag sets when transmit path empty or byte moved on.
// - Start edge validated by low level after 7.5 ticks of 16x.
// - Baud divider uses 16-bit divisor 2..65535 giving 16x rate.
// - Mask bits 0..3 gate receive, holding empty, line, modem; upper zero.
// - Source code bits 2..1 by priority; bit 0 low when pending.
// - Only highest pending source reported until serviced.
// - Format bits 1..0 select 5 to 8 data bits.
// - Format bit 2 gives 1.5 stops for 5 bits, else two.
// - Format bit 3 enables parity; bit 4 selects even.
// - Format bit 5 forces parity to inverse of bit 4.
// - Format bit 6 holds serial output low for break, outside loopback.
// - Format bit 7 maps offsets 0 and 1 to divisor bytes.
// - Control bits 0,1 drive terminal-ready and send-request low when set, outside loopback.
// - Control bit 3 enables interrupt output and drives aux2 low outside loopback.
// - Control bit 4 loops transmitter to receiver and modem outputs back.
// - In loopback modem changes come from low control bits.
// - Line status bits 0..4: ready, overrun, parity, framing, break.
// - Status bit 5 holding empty, bit 6 all empty, bit 7 zero.
// - Modem deltas set on change, bell on trailing edge; cleared by read.
// - Modem bits 4..7 are inverted inputs, or control bits in loopback.
// - Reset clears mask, format, control; source 01; status 0x60.
// - Three address lines select the eight registers.
// - Chip select with low strobes writes or reads registers.
// - Interrupt high while any enabled condition is present.
// - Reset clears outputs and registers, idles serial lines.
module asc_channel (
  input wire clk_i,              // Clock 100 MHz
  input wire sys_rst_i,          // Master reset, async high
  input wire chip_sel_n_i,       // Chip select, low
  input wire [2:0] addr_i,       // Register address
  input wire read_strobe_n_i,    // Read strobe, low
  input wire write_strobe_n_i,   // Write strobe, low
  input wire [7:0] data_i,       // Bus data in
  output reg [7:0] data_o,       // Bus data out
  output reg data_oe_n_o,        // Bus drive enable, low drives
  input wire serial_in_i,        // Serial receive
  output reg serial_out_o,       // Serial transmit
  input wire clear_send_n_i,     // Clear-to-send in, low
  input wire set_ready_n_i,      // Set-ready in, low
  input wire bell_in_n_i,        // Ring indicator in, low
  input wire carrier_detect_n_i, // Carrier in, low
  output reg term_ready_n_o,     // Terminal-ready out, low
  output reg send_req_n_o,       // Send-request out, low
  output reg aux_out1_n_o,       // Auxiliary 1 out, low
  output reg aux_out2_n_o,       // Auxiliary 2 out, low
  output reg irq_o,              // Interrupt, high
  output reg irq_oe_n_o,         // Interrupt drive enable, low drives
  output reg recv_avail_o,       // Receive data ready
  output reg xmit_space_o        // Holding register empty
);
  localparam TX_IDLE = 5'b00001;
  localparam TX_START = 5'b00010;
  localparam TX_DATA = 5'b00100;
  localparam TX_PAR = 5'b01000;
  localparam TX_STOP = 5'b10000;
  localparam RX_IDLE = 4'b0001;
  localparam RX_START = 4'b0010;
  localparam RX_DATA = 4'b0100;
  localparam RX_STOPB = 4'b1000;

  reg [7:0] irq_mask;
  reg [7:0] line_format;
  reg [4:0] modem_control;
  reg [7:0] scratch;
  reg [7:0] divisor_low;
  reg [7:0] divisor_high;
  reg [7:0] recv_hold_reg;
  reg [4:0] lstat;
  reg [3:0] mdelta;
  reg [3:0] mprev;
  reg thr_irq;
  reg rd_q;
  reg wr_q;
  wire tick;
  wire rd_now;
  wire wr_now;
  wire rd_pulse;
  wire wr_pulse;
  wire div_access;
  wire loop;
  wire [3:0] mnow;
  wire [3:0] data_bits;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  reg fifo_pop;
  reg [4:0] tx_state;
  reg [7:0] xmit_shift_reg;
  reg [3:0] tx_tick;
  reg [3:0] tx_cnt;
  reg tx_par;
  reg tx_line;
  reg [3:0] rx_state;
  reg [3:0] rx_tick;
  reg [3:0] rx_cnt;
  reg [7:0] rx_shift;
  reg rx_par;
  reg rx_prev;
  wire rx_line;
  wire tx_busy;
  wire hold_empty;
  wire all_empty;
  reg [2:0] next_src;
  reg [7:0] next_rd;

  asc_baud u_baud (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .div_i({divisor_high, divisor_low}),
    .tick_o(tick)
  );

  assign rd_now = !chip_sel_n_i && !read_strobe_n_i;
  assign wr_now = !chip_sel_n_i && !write_strobe_n_i;
  assign rd_pulse = rd_now && !rd_q;
  assign wr_pulse = wr_now && !wr_q;
  assign div_access = line_format[`ASC_FMT_DIV];
  assign loop = modem_control[`ASC_MC_LOOP];
  assign data_bits = 4'h5 + {2'b00, line_format[1:0]};

  // Writes while buffer full are dropped
  asc_fifo #(
    .WIDTH(8),
    .DEPTH(`ASC_FIFO_DEPTH),
    .AW(`ASC_FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(wr_pulse && !div_access && addr_i == `ASC_OFF_HOLD),
    .in_ready_o(fifo_in_ready),
    .in_data_i(data_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  assign tx_busy = (tx_state != TX_IDLE);
  // holding empty once bytes reach the shifter
  assign hold_empty = !fifo_out_valid;
  assign all_empty = hold_empty && !tx_busy;

  assign rx_line = loop ? tx_line : serial_in_i;
  // modem inputs as true levels: cts, dsr, ri, cd
  assign mnow = loop ? {modem_control[3], modem_control[2],
                        modem_control[0], modem_control[1]}
                     : {~carrier_detect_n_i, ~bell_in_n_i,
                        ~set_ready_n_i, ~clear_send_n_i};

  // Priority source, highest first
  always @* begin
    next_src = `ASC_SRC_NONE;
    if (irq_mask[2] && (|lstat[4:1])) begin
      next_src = `ASC_SRC_LINE;
    end else if (irq_mask[0] && lstat[0]) begin
      next_src = `ASC_SRC_RXD;
    end else if (irq_mask[1] && thr_irq) begin
      next_src = `ASC_SRC_THE;
    end else if (irq_mask[3] && (|mdelta)) begin
      next_src = `ASC_SRC_MDM;
    end
  end

  always @* begin
    next_rd = 8'h00;
    case (addr_i)
      `ASC_OFF_HOLD: next_rd = div_access ? divisor_low : recv_hold_reg;
      `ASC_OFF_MASK: next_rd = div_access ? divisor_high : {4'h0, irq_mask[3:0]};
      `ASC_OFF_SRC: next_rd = {5'b00000, next_src};
      `ASC_OFF_FMT: next_rd = line_format;
      `ASC_OFF_MCTL: next_rd = {3'b000, modem_control};
      `ASC_OFF_LSTAT: next_rd = {1'b0, all_empty, hold_empty, lstat};
      `ASC_OFF_MSTAT: next_rd = {mnow[3], mnow[2], mnow[1], mnow[0], mdelta};
      `ASC_OFF_SCR: next_rd = scratch;
      default: next_rd = 8'h00;
    endcase
  end

  // Register file and status
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_mask <= `ASC_RST_MASK;
      line_format <= `ASC_RST_FMT;
      modem_control <= 5'h00;
      scratch <= 8'h00;
      divisor_low <= 8'h00;
      divisor_high <= 8'h00;
      lstat <= 5'h00;
      mdelta <= 4'h0;
      mprev <= 4'h0;
      thr_irq <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      data_o <= 8'h00;
      data_oe_n_o <= 1'b1;
    end else begin
      rd_q <= rd_now;
      wr_q <= wr_now;
      mprev <= mnow;
      data_oe_n_o <= !rd_now;
      if (rd_pulse) begin
        data_o <= next_rd;
      end
      if (wr_pulse) begin
        case (addr_i)
          `ASC_OFF_HOLD: if (div_access) divisor_low <= data_i;
          `ASC_OFF_MASK: begin
            if (div_access) begin
              divisor_high <= data_i;
            end else begin
              irq_mask <= {4'h0, data_i[3:0]};
            end
          end
          `ASC_OFF_FMT: line_format <= data_i;
          `ASC_OFF_MCTL: modem_control <= data_i[4:0];
          `ASC_OFF_SCR: scratch <= data_i;
          default: scratch <= scratch;
        endcase
      end
      // Holding-empty source: set on each pop to the shifter, cleared by write or source read
      if (fifo_pop && fifo_out_valid) begin
        thr_irq <= 1'b1;
      end else if (wr_pulse && !div_access && addr_i == `ASC_OFF_HOLD) begin
        thr_irq <= 1'b0;
      end else if (rd_pulse && addr_i == `ASC_OFF_SRC && next_src == `ASC_SRC_THE) begin
        thr_irq <= 1'b0;
      end
      // deltas, set wins over read clear
      if (rd_pulse && addr_i == `ASC_OFF_MSTAT) begin
        mdelta <= {mnow[3] ^ mprev[3], mprev[2] & ~mnow[2],
                   mnow[1] ^ mprev[1], mnow[0] ^ mprev[0]};
      end else begin
        mdelta <= mdelta | {mnow[3] ^ mprev[3], mprev[2] & ~mnow[2],
                            mnow[1] ^ mprev[1], mnow[0] ^ mprev[0]};
      end
      if (rd_pulse && !div_access && addr_i == `ASC_OFF_HOLD) begin
        lstat[0] <= 1'b0;
      end
      if (rd_pulse && addr_i == `ASC_OFF_LSTAT) begin
        lstat[4:1] <= 4'h0;
      end
      if (tick && rx_state == RX_STOPB && rx_tick == `ASC_BIT_TICKS) begin
        lstat[0] <= 1'b1;
        lstat[1] <= lstat[0] | lstat[1];
        lstat[2] <= line_format[`ASC_FMT_PAR_EN] & rx_par;
        lstat[3] <= !rx_line;
        lstat[4] <= !rx_line && rx_shift == 8'h00 && !rx_par;
      end
    end
  end

  // Transmitter
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_state <= TX_IDLE;
      xmit_shift_reg <= 8'h00;
      tx_tick <= 4'h0;
      tx_cnt <= 4'h0;
      tx_par <= 1'b0;
      tx_line <= 1'b1;
      fifo_pop <= 1'b0;
    end else begin
      fifo_pop <= 1'b0;
      if (tick) begin
        tx_tick <= tx_tick + 4'h1;
        case (tx_state)
          TX_IDLE: begin
            tx_tick <= 4'h0;
            tx_line <= 1'b1;
            if (fifo_out_valid && !fifo_pop) begin
              xmit_shift_reg <= fifo_out_data;
              fifo_pop <= 1'b1;
              tx_par <= 1'b0;
              tx_line <= 1'b0;
              tx_state <= TX_START;
            end
          end
          TX_START: if (tx_tick == `ASC_BIT_TICKS) begin
            tx_line <= xmit_shift_reg[0];
            tx_par <= xmit_shift_reg[0];
            xmit_shift_reg <= {1'b0, xmit_shift_reg[7:1]};
            tx_cnt <= 4'h1;
            tx_state <= TX_DATA;
          end
          TX_DATA: if (tx_tick == `ASC_BIT_TICKS) begin
            if (tx_cnt == data_bits) begin
              if (line_format[`ASC_FMT_PAR_EN]) begin
                tx_line <= line_format[`ASC_FMT_STICK] ? !line_format[`ASC_FMT_EVEN]
                         : (tx_par ^ !line_format[`ASC_FMT_EVEN]);
                tx_state <= TX_PAR;
              end else begin
                tx_line <= 1'b1;
                tx_cnt <= 4'h0;
                tx_state <= TX_STOP;
              end
            end else begin
              tx_line <= xmit_shift_reg[0];
              tx_par <= tx_par ^ xmit_shift_reg[0];
              xmit_shift_reg <= {1'b0, xmit_shift_reg[7:1]};
              tx_cnt <= tx_cnt + 4'h1;
            end
          end
          TX_PAR: if (tx_tick == `ASC_BIT_TICKS) begin
            tx_line <= 1'b1;
            tx_cnt <= 4'h0;
            tx_state <= TX_STOP;
          end
          TX_STOP: begin
            // one, one and a half or two stops, in half bits
            if (tx_tick == `ASC_BIT_TICKS || tx_tick == `ASC_START_MID) begin
              tx_cnt <= tx_cnt + 4'h1;
              if (tx_cnt + 4'h1 >= (!line_format[2] ? 4'h2 :
                  (line_format[1:0] == 2'b00 ? 4'h3 : 4'h4))) begin
                tx_state <= TX_IDLE;
              end
            end
          end
          default: tx_state <= TX_IDLE;
        endcase
      end
    end
  end

  // Receiver
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_state <= RX_IDLE;
      rx_tick <= 4'h0;
      rx_cnt <= 4'h0;
      rx_shift <= 8'h00;
      rx_par <= 1'b0;
      rx_prev <= 1'b1;
      recv_hold_reg <= 8'h00;
    end else if (tick) begin
      rx_prev <= rx_line;
      rx_tick <= rx_tick + 4'h1;
      case (rx_state)
        RX_IDLE: begin
          rx_tick <= 4'h0;
          if (rx_prev && !rx_line) begin
            rx_state <= RX_START;
          end
        end
        RX_START: if (rx_tick == `ASC_START_MID - 4'h1) begin
          if (rx_line) begin
            rx_state <= RX_IDLE;
          end else begin
            rx_tick <= 4'h0;
            rx_cnt <= 4'h0;
            rx_shift <= 8'h00;
            rx_par <= 1'b0;
            rx_state <= RX_DATA;
          end
        end
        RX_DATA: if (rx_tick == `ASC_BIT_TICKS) begin
          if (rx_cnt < data_bits) begin
            rx_shift <= {rx_line, rx_shift[7:1]};
            rx_par <= rx_par ^ rx_line;
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt + 4'h1 == data_bits && !line_format[`ASC_FMT_PAR_EN]) begin
              rx_state <= RX_STOPB;
            end
          end else begin
            rx_par <= line_format[`ASC_FMT_STICK] ? (rx_line == line_format[`ASC_FMT_EVEN])
                    : (rx_par ^ rx_line ^ !line_format[`ASC_FMT_EVEN]);
            rx_state <= RX_STOPB;
          end
        end
        RX_STOPB: if (rx_tick == `ASC_BIT_TICKS) begin
          recv_hold_reg <= rx_shift >> (4'h8 - data_bits);
          rx_state <= RX_IDLE;
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Registered pin outputs
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      serial_out_o <= 1'b1;
      term_ready_n_o <= 1'b1;
      send_req_n_o <= 1'b1;
      aux_out1_n_o <= 1'b1;
      aux_out2_n_o <= 1'b1;
      irq_o <= 1'b0;
      irq_oe_n_o <= 1'b1;
      recv_avail_o <= 1'b0;
      xmit_space_o <= 1'b1;
    end else begin
      // break and loopback on the pin
      serial_out_o <= loop ? 1'b1 : (tx_line && !line_format[`ASC_FMT_BRK]);
      // modem outputs, forced inactive in loopback
      term_ready_n_o <= loop ? 1'b1 : !modem_control[0];
      send_req_n_o <= loop ? 1'b1 : !modem_control[1];
      aux_out1_n_o <= loop ? 1'b1 : !modem_control[2];
      aux_out2_n_o <= loop ? 1'b1 : !modem_control[`ASC_MC_IRQ_EN];
      irq_oe_n_o <= !modem_control[`ASC_MC_IRQ_EN];
      irq_o <= (next_src != `ASC_SRC_NONE);
      recv_avail_o <= lstat[0];
      xmit_space_o <= hold_empty;
    end
  end
endmodule

// ---- verif/asc_channel_asserts.sv ----
// Purpose: port-level checks for the serial channel
// Assumes: bus strobes sampled on clk_i, divisor at least 2
// Notes: sees only top-level ports
`timescale 1ns/1ps
module asc_channel_asserts (
  input wire clk_i,           // Clock
  input wire sys_rst_i,       // Reset
  input wire chip_sel_n_i,    // Select
  input wire [2:0] addr_i,    // Offset
  input wire read_strobe_n_i, // Read
  input wire write_strobe_n_i, // Write
  input wire [7:0] data_o,    // Read data
  input wire data_oe_n_o,     // Bus enable
  input wire serial_out_o,    // Serial out
  input wire term_ready_n_o,  // Modem out
  input wire send_req_n_o,    // Modem out
  input wire aux_out2_n_o,    // Aux 2
  input wire irq_oe_n_o,      // Irq enable
  input wire xmit_space_o,    // Holding empty
  input wire recv_avail_o     // Data ready
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Only the first edge of a low strobe counts as an access
  sequence rd_take;
    !chip_sel_n_i && !read_strobe_n_i && $past(read_strobe_n_i);
  endsequence
  a_read_drives_bus: assert property (rd_take |=> !data_oe_n_o)
    else $error("bus not driven after read");
  a_bus_released: assert property (read_strobe_n_i && $past(read_strobe_n_i) |-> data_oe_n_o)
    else $error("bus driven without read");
  a_status_top_zero: assert property (rd_take and addr_i == 3'h5
    |=> !data_o[7] && (!data_o[6] || data_o[5])) else $error("line status bits wrong");
  a_source_code_legal: assert property (rd_take and addr_i == 3'h2
    |=> data_o[7:3] == 5'h00 && (!data_o[0] || data_o[2:1] == 2'b00))
    else $error("irq source code wrong");
  a_control_top_zero: assert property (rd_take and addr_i == 3'h4 |=> data_o[7:5] == 3'h0)
    else $error("modem control top bits set");
  a_reset_idle: assert property ($fell(sys_rst_i) |-> serial_out_o && term_ready_n_o
    && send_req_n_o && aux_out2_n_o && irq_oe_n_o && data_oe_n_o && xmit_space_o && !recv_avail_o)
    else $error("outputs not idle after reset");
  // A divisor of 2 gives the shortest bit of 32 clocks
  a_line_low_min: assert property ($fell(serial_out_o) |-> !serial_out_o [*8])
    else $error("serial low too short");
  a_modem_by_write: assert property ($changed({term_ready_n_o, send_req_n_o, irq_oe_n_o})
    |-> !write_strobe_n_i || $past(!write_strobe_n_i) || $past(!write_strobe_n_i, 2))
    else $error("modem output moved without write");
  a_irq_pin_pair: assert property (!aux_out2_n_o |-> !irq_oe_n_o)
    else $error("aux 2 low with irq off");
  cover property (rd_take and addr_i == 3'h2);
  cover property ($fell(serial_out_o));
  cover property ($rose(recv_avail_o));
endmodule
bind asc_channel asc_channel_asserts asc_channel_asserts_i (.*);

// ---- verif/asc_serial_peer.sv ----
// Purpose: far-side serial and modem peer
// Assumes: 8 data bits, no parity, one stop, BIT clocks a bit
// Notes: line idles high, modem lines released high
`timescale 1ns/1ps
module asc_serial_peer #(
  parameter BIT = 32
) (
  input wire clk_i,          // Clock
  input wire line_i,         // From device
  output reg line_o,         // To device
  output reg [3:0] modem_n_o // Carrier, bell, ready, clear
);
  reg [7:0] got = 8'h00;
  integer n_got = 0;
  integer k;
  initial line_o = 1'b1;
  initial modem_n_o = 4'hf;
  task send(input [7:0] b);
    integer j;
    reg [9:0] fr;
    begin
      fr = {1'b1, b, 1'b0};
      for (j = 0; j < 10; j = j + 1) begin
        @(posedge clk_i);
        line_o <= fr[j];
        repeat (BIT - 1) @(posedge clk_i);
      end
    end
  endtask
  task glitch(input integer n);
    begin
      @(posedge clk_i);
      line_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      line_o <= 1'b1;
    end
  endtask
  // Settle time lets the modem delta bits register the change
  task set_modem(input [3:0] v);
    begin
      @(posedge clk_i);
      modem_n_o <= v;
      repeat (4) @(posedge clk_i);
    end
  endtask
  always begin
    @(negedge line_i);
    repeat (BIT / 2) @(posedge clk_i);
    if (!line_i) begin
      for (k = 0; k < 8; k = k + 1) begin
        repeat (BIT) @(posedge clk_i);
        got[k] = line_i;
      end
      repeat (BIT) @(posedge clk_i);
      if (line_i) n_got = n_got + 1;
    end
  end
endmodule

// ---- verif/asc_channel_bench.sv ----
// Purpose: register-level bench for the serial channel
// Assumes: divisor 2, so one bit is 32 clocks
// Notes: far side is the serial peer model
`timescale 1ns/1ps
module asc_channel_bench;
  reg clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg rd_n = 1'b1;
  reg wr_n = 1'b1;
  reg [2:0] addr = 3'h0;
  reg [7:0] wdata = 8'h00;
  reg [7:0] q;
  wire cs_n = rd_n & wr_n;
  wire [7:0] data_o;
  wire [3:0] mdm_n;
  wire rx_line, serial_out_o, data_oe_n_o, term_ready_n_o, send_req_n_o;
  wire aux_out1_n_o, aux_out2_n_o, irq_o, irq_oe_n_o, recv_avail_o, xmit_space_o;
  integer n_errors = 0;
  integer n_compared = 0;
  integer n0;
  always #5 clk_i = ~clk_i;
  asc_channel asc_channel_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .chip_sel_n_i(cs_n),
    .addr_i(addr), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .data_i(wdata),
    .data_o(data_o), .data_oe_n_o(data_oe_n_o), .serial_in_i(rx_line),
    .serial_out_o(serial_out_o), .clear_send_n_i(mdm_n[0]), .set_ready_n_i(mdm_n[1]),
    .bell_in_n_i(mdm_n[2]), .carrier_detect_n_i(mdm_n[3]), .term_ready_n_o(term_ready_n_o),
    .send_req_n_o(send_req_n_o), .aux_out1_n_o(aux_out1_n_o), .aux_out2_n_o(aux_out2_n_o),
    .irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o), .recv_avail_o(recv_avail_o),
    .xmit_space_o(xmit_space_o));
  asc_serial_peer #(.BIT(32)) asc_serial_peer_i (.clk_i(clk_i), .line_i(serial_out_o),
    .line_o(rx_line), .modem_n_o(mdm_n));
  task stop_test;
    begin
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] s);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("Error %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // Strobe low for one edge, then released, so a fresh access always sees it high first
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr_n <= 1'b0;
      @(posedge clk_i);
      wr_n <= 1'b1;
      @(posedge clk_i);
      @(negedge clk_i);
    end
  endtask
  task acc_rd(input [2:0] a, output [7:0] v);
    begin
      @(posedge clk_i);
      addr <= a;
      rd_n <= 1'b0;
      repeat (3) @(posedge clk_i);
      v = data_o;
      rd_n <= 1'b1;
      @(posedge clk_i);
    end
  endtask
  task rd(input [2:0] a, input [7:0] e);
    begin
      acc_rd(a, q);
      chk($sformatf("reg %0d", a), e, q);
    end
  endtask
  task wait_rx;
    integer k;
    begin
      for (k = 0; k < 2000 && recv_avail_o !== 1'b1; k = k + 1) @(posedge clk_i);
      chk("recv avail", 8'h01, {7'h0, recv_avail_o});
      if (recv_avail_o !== 1'b1) stop_test;
    end
  endtask
  task wait_tx;
    integer k;
    begin
      q = 8'h00;
      for (k = 0; k < 200 && q !== 8'h60; k = k + 1) acc_rd(3'h5, q);
      chk("line status", 8'h60, q);
      if (q !== 8'h60) stop_test;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h01);
    rd(3'h3, 8'h00);
    rd(3'h4, 8'h00);
    rd(3'h5, 8'h60);
    $display("test reset values done");
    wr(3'h7, 8'ha5);
    rd(3'h7, 8'ha5);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h02);
    wr(3'h1, 8'h00);
    rd(3'h0, 8'h02);
    wr(3'h3, 8'h03);
    rd(3'h1, 8'h00);
    wr(3'h4, 8'h0b);
    chk("modem pins", 8'h10, {3'h0, aux_out1_n_o, aux_out2_n_o, irq_oe_n_o, send_req_n_o,
      term_ready_n_o});
    $display("test access done");
    wr(3'h0, 8'ha5);
    chk("hold empty", 8'h00, {7'h0, xmit_space_o});
    wait_tx;
    chk("peer byte", 8'ha5, asc_serial_peer_i.got);
    $display("test transmit done");
    asc_serial_peer_i.glitch(10);
    repeat (400) @(posedge clk_i);
    chk("noise start", 8'h00, {7'h0, recv_avail_o});
    wr(3'h1, 8'h05);
    asc_serial_peer_i.send(8'h3c);
    asc_serial_peer_i.send(8'hc3);
    wait_rx;
    rd(3'h2, 8'h06);
    chk("irq", 8'h01, {7'h0, irq_o});
    rd(3'h5, 8'h63);
    rd(3'h2, 8'h04);
    rd(3'h0, 8'hc3);
    rd(3'h2, 8'h01);
    $display("test receive done");
    wr(3'h1, 8'h08);
    asc_serial_peer_i.set_modem(4'h6);
    rd(3'h2, 8'h00);
    rd(3'h6, 8'h99);
    rd(3'h6, 8'h90);
    asc_serial_peer_i.set_modem(4'h9);
    rd(3'h6, 8'h6b);
    asc_serial_peer_i.set_modem(4'hf);
    rd(3'h6, 8'h06);
    $display("test modem done");
    n0 = asc_serial_peer_i.n_got;
    wr(3'h4, 8'h1b);
    repeat (4) @(posedge clk_i);
    rd(3'h2, 8'h00);
    rd(3'h6, 8'hbb);
    wr(3'h0, 8'h5a);
    wait_rx;
    rd(3'h0, 8'h5a);
    chk("line idle", 8'h01, {7'h0, serial_out_o});
    chk("peer frames", n0[7:0], asc_serial_peer_i.n_got[7:0]);
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h43);
    repeat (10) @(posedge clk_i);
    chk("break", 8'h00, {7'h0, serial_out_o});
    $display("test loopback and break done");
    stop_test;
  end
endmodule
